// [rtl/pafe_defines.svh]
// Purpose: Offsets, field positions and reset values of the slot config bank
// Assumes: 32-bit AXI4-Lite data, 16-bit registers in the low half
// Notes:   Printed offsets are register indices; byte address is index * 4
`ifndef PAFE_DEFINES_SVH
`define PAFE_DEFINES_SVH

// Register indices as printed
`define PAFE_IDX_WINDOW      8'h39
`define PAFE_IDX_MODE        8'h42
`define PAFE_IDX_INT_ENABLE  8'h58
`define PAFE_IDX_INT_OPTIONS 8'h5a

// Byte addresses on the bus
`define PAFE_ADDR_WINDOW      ({`PAFE_IDX_WINDOW, 2'b00})
`define PAFE_ADDR_MODE        ({`PAFE_IDX_MODE, 2'b00})
`define PAFE_ADDR_INT_ENABLE  ({`PAFE_IDX_INT_ENABLE, 2'b00})
`define PAFE_ADDR_INT_OPTIONS ({`PAFE_IDX_INT_OPTIONS, 2'b00})

// Reset values of whole registers
`define PAFE_RST_WINDOW      16'h22fc
`define PAFE_RST_MODE        16'h1c38
`define PAFE_RST_INT_ENABLE  16'h0000
`define PAFE_RST_INT_OPTIONS 16'h0000

// Window register fields
`define PAFE_WIN_WIDTH_HI  15
`define PAFE_WIN_WIDTH_LO  11
`define PAFE_WIN_COARSE_HI 10
`define PAFE_WIN_COARSE_LO 5
`define PAFE_WIN_FINE_HI   4
`define PAFE_WIN_FINE_LO   0

// Mode register fields
`define PAFE_MODE_CODE_HI   15
`define PAFE_MODE_CODE_LO   8
`define PAFE_MODE_BYPASS    7
`define PAFE_MODE_IND_GAIN  6
`define PAFE_MODE_BIAS_HI   5
`define PAFE_MODE_BIAS_LO   4
`define PAFE_MODE_GAIN_HI   1
`define PAFE_MODE_GAIN_LO   0

// Enable and option register fields
`define PAFE_EN_SECOND_INT  13
`define PAFE_EN_FIRST_INT   12
`define PAFE_OPT_GAPPED     7
`define PAFE_OPT_SECOND_PAIR 6
`define PAFE_OPT_FIRST_PAIR 5

// Chain mode codes
`define PAFE_CODE_NORMAL    8'h1c
`define PAFE_CODE_DIG_INT   8'h1d

// Fine steps (31.25 ns) per coarse step (1 us)
`define PAFE_FINE_PER_US    32

// AXI responses
`define PAFE_RESP_OKAY      2'b00
`define PAFE_RESP_SLVERR    2'b10

`endif

// [rtl/pafe_pkg.sv]
// Purpose: Shared types of the slot config bank
// Assumes: Nothing beyond the defines header
// Notes:   Constants live in the header, types here
package pafe_pkg;

   // Which register an address selects
   typedef enum logic [2:0] {
      PAFE_SEL_NONE    = 3'b000,
      PAFE_SEL_WINDOW  = 3'b001,
      PAFE_SEL_MODE    = 3'b010,
      PAFE_SEL_ENABLE  = 3'b011,
      PAFE_SEL_OPTIONS = 3'b100
   } pafe_sel_type;

endpackage

// [rtl/pafe_slot_config.sv]
// Purpose: Slot timing and front-end configuration bank on AXI4-Lite
// Assumes: One clock, async active-low reset, one access of each kind at a time
// Notes:   Derived controls are registered, so they lag a write by one cycle
//
// How it works
// - Enable bits 13/12 pick digital integration per slot
// - Gap zero unless gapped bit, then fine delay
// - Pair bit one means single, zero double
// - Window width bits 15:11, reset 4
// - Coarse delay bits 10:5, reset 0x17
// - Fine delay bits 4:0, 31.25ns, reset 0x1C
// - Integrator bypass on bit 7 or digital integrate
// - Individual gain: ch1 local, ch2-4 external register
// - Shared gain code drives all four channels when bit 6 is clear
// - Amplifier bias from bits 5:4, reset 3
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/100ps
`include "pafe_defines.svh"

module pafe_slot_config #(
   parameter int ADDR_W = 10                      // Byte address width
) (
   input  wire logic              clock,
   input  wire logic              rstn,
   // AXI4-Lite write address
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]        s_axi_awprot,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]        s_axi_arprot,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Inputs from neighbouring blocks
   input  wire logic              second_slot_active,
   input  wire logic [4:0]        second_slot_window_fine_delay,
   input  wire logic [5:0]        ext_channel_gain,
   // Timing core controls
   output logic                   second_slot_integrate_select,
   output logic                   first_slot_integrate_select,
   output logic                   second_slot_pair_count_select,
   output logic                   first_slot_pair_count_select,
   output logic [4:0]             region_gap,
   output logic [4:0]             first_slot_window_width,
   output logic [5:0]             first_slot_window_coarse_delay,
   output logic [4:0]             first_slot_window_fine_delay,
   output logic [10:0]            first_slot_window_start,
   // Front-end controls
   output logic [7:0]             first_slot_chain_mode_code,
   output logic                   first_slot_integrator_bypass,
   output logic [1:0]             first_slot_amp_bias_select,
   output logic [1:0]             first_slot_ch1_gain,
   output logic [1:0]             first_slot_ch2_gain,
   output logic [1:0]             first_slot_ch3_gain,
   output logic [1:0]             first_slot_ch4_gain
);

   ////////////////////////////////////////////////////////////////////////////
   // Address decode

   // Map a byte address onto a register; misaligned or unknown is none
   function automatic pafe_pkg::pafe_sel_type decode(input logic [ADDR_W-1:0] addr);
      pafe_pkg::pafe_sel_type sel;
      sel = pafe_pkg::PAFE_SEL_NONE;
      if (addr == ADDR_W'(`PAFE_ADDR_WINDOW)) begin
         sel = pafe_pkg::PAFE_SEL_WINDOW;
      end else if (addr == ADDR_W'(`PAFE_ADDR_MODE)) begin
         sel = pafe_pkg::PAFE_SEL_MODE;
      end else if (addr == ADDR_W'(`PAFE_ADDR_INT_ENABLE)) begin
         sel = pafe_pkg::PAFE_SEL_ENABLE;
      end else if (addr == ADDR_W'(`PAFE_ADDR_INT_OPTIONS)) begin
         sel = pafe_pkg::PAFE_SEL_OPTIONS;
      end
      return sel;
   endfunction

   // Merge the low two byte lanes of a write into a 16-bit register
   function automatic logic [15:0] merge(input logic [15:0] old_val,
                                         input logic [31:0] data,
                                         input logic [3:0]  strb);
      logic [15:0] res;
      res = old_val;
      if (strb[0]) begin
         res[7:0] = data[7:0];
      end
      if (strb[1]) begin
         res[15:8] = data[15:8];
      end
      return res;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Write channel

   logic [ADDR_W-1:0] aw_addr_q;                  // Held write address
   logic              aw_held_q;                  // Address taken, awaiting data
   logic [31:0]       w_data_q;                   // Held write data
   logic [3:0]        w_strb_q;                   // Held strobes
   logic              w_held_q;                   // Data taken, awaiting address
   logic              bvalid_q;                   // Response pending
   logic [1:0]        bresp_q;                    // Response code
   logic              do_write;                   // Both halves present this cycle
   pafe_pkg::pafe_sel_type wr_sel;                // Target of the write

   // Each half is taken once; no new one until the response is gone
   assign s_axi_awready = !aw_held_q && !bvalid_q;
   assign s_axi_wready  = !w_held_q && !bvalid_q;
   assign do_write      = aw_held_q && w_held_q && !bvalid_q;
   assign wr_sel        = decode(aw_addr_q);
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;

   // Capture address and data in either order
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         aw_addr_q <= '0;
         aw_held_q <= 1'b0;
         w_data_q  <= 32'h0000_0000;
         w_strb_q  <= 4'h0;
         w_held_q  <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_q <= s_axi_awaddr;
            aw_held_q <= 1'b1;
         end else if (do_write) begin
            aw_held_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
            w_held_q <= 1'b1;
         end else if (do_write) begin
            w_held_q <= 1'b0;
         end
      end
   end

   // Response one cycle after both halves meet
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         bvalid_q <= 1'b0;
         bresp_q  <= `PAFE_RESP_OKAY;
      end else if (do_write) begin
         bvalid_q <= 1'b1;
         // Unmapped address answers with a slave error
         bresp_q  <= (wr_sel == pafe_pkg::PAFE_SEL_NONE) ? `PAFE_RESP_SLVERR
                                                          : `PAFE_RESP_OKAY;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   logic [15:0] window_q;                         // Integration window
   logic [15:0] mode_q;                           // Front-end mode
   logic [15:0] enable_q;                         // Digital integration enable
   logic [15:0] options_q;                        // Digital integration options

   // All bits writable, reserved ones included, and read back as written
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         window_q  <= `PAFE_RST_WINDOW;
         mode_q    <= `PAFE_RST_MODE;
         enable_q  <= `PAFE_RST_INT_ENABLE;
         options_q <= `PAFE_RST_INT_OPTIONS;
      end else if (do_write) begin
         case (wr_sel)
            pafe_pkg::PAFE_SEL_WINDOW: begin
               window_q <= merge(window_q, w_data_q, w_strb_q);
            end
            // Mode code is stored as given; software keeps it legal
            pafe_pkg::PAFE_SEL_MODE: begin
               mode_q <= merge(mode_q, w_data_q, w_strb_q);
            end
            pafe_pkg::PAFE_SEL_ENABLE: begin
               enable_q <= merge(enable_q, w_data_q, w_strb_q);
            end
            pafe_pkg::PAFE_SEL_OPTIONS: begin
               options_q <= merge(options_q, w_data_q, w_strb_q);
            end
            default: begin
               // Unmapped: nothing stored
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read channel

   logic        rvalid_q;                         // Read data pending
   logic [31:0] rdata_q;                          // Read data
   logic [1:0]  rresp_q;                          // Read response
   logic [15:0] rd_word;                          // Selected register
   pafe_pkg::pafe_sel_type rd_sel;                // Target of the read

   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;
   assign rd_sel        = decode(s_axi_araddr);

   // Read mux; unmapped reads as zero
   always_comb begin
      case (rd_sel)
         pafe_pkg::PAFE_SEL_WINDOW:  rd_word = window_q;
         pafe_pkg::PAFE_SEL_MODE:    rd_word = mode_q;
         pafe_pkg::PAFE_SEL_ENABLE:  rd_word = enable_q;
         pafe_pkg::PAFE_SEL_OPTIONS: rd_word = options_q;
         default:                    rd_word = 16'h0000;
      endcase
   end

   // Data one cycle after the address is taken; upper half reads zero
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= `PAFE_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_q <= 1'b1;
         rdata_q  <= {16'h0000, rd_word};
         rresp_q  <= (rd_sel == pafe_pkg::PAFE_SEL_NONE) ? `PAFE_RESP_SLVERR
                                                         : `PAFE_RESP_OKAY;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Timing core controls

   logic [4:0] active_fine;                       // Fine delay of the running slot

   // The gap borrows the fine delay of whichever slot is running
   assign active_fine = second_slot_active ? second_slot_window_fine_delay
                                           : window_q[`PAFE_WIN_FINE_HI:`PAFE_WIN_FINE_LO];

   // Registered so the analog side never sees a decode glitch
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         second_slot_integrate_select   <= 1'b0;
         first_slot_integrate_select    <= 1'b0;
         second_slot_pair_count_select  <= 1'b0;
         first_slot_pair_count_select   <= 1'b0;
         region_gap                     <= 5'h00;
         first_slot_window_width        <= 5'h00;
         first_slot_window_coarse_delay <= 6'h00;
         first_slot_window_fine_delay   <= 5'h00;
         first_slot_window_start        <= 11'h000;
      end else begin
         second_slot_integrate_select   <= enable_q[`PAFE_EN_SECOND_INT];
         first_slot_integrate_select    <= enable_q[`PAFE_EN_FIRST_INT];
         // One selects single pair, zero double pair
         second_slot_pair_count_select  <= options_q[`PAFE_OPT_SECOND_PAIR];
         first_slot_pair_count_select   <= options_q[`PAFE_OPT_FIRST_PAIR];
         // No gap between regions unless gapped mode is on
         region_gap <= options_q[`PAFE_OPT_GAPPED] ? active_fine : 5'h00;
         first_slot_window_width <=
            window_q[`PAFE_WIN_WIDTH_HI:`PAFE_WIN_WIDTH_LO];
         first_slot_window_coarse_delay <=
            window_q[`PAFE_WIN_COARSE_HI:`PAFE_WIN_COARSE_LO];
         first_slot_window_fine_delay <=
            window_q[`PAFE_WIN_FINE_HI:`PAFE_WIN_FINE_LO];
         // Start in 31.25 ns steps: coarse microseconds plus fine steps
         first_slot_window_start <=
            11'(window_q[`PAFE_WIN_COARSE_HI:`PAFE_WIN_COARSE_LO] * `PAFE_FINE_PER_US)
            + 11'(window_q[`PAFE_WIN_FINE_HI:`PAFE_WIN_FINE_LO]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Front-end controls

   logic [1:0] shared_gain;                       // Gain code field
   logic       ind_gain;                          // Per-channel gain enabled

   assign shared_gain = mode_q[`PAFE_MODE_GAIN_HI:`PAFE_MODE_GAIN_LO];
   assign ind_gain    = mode_q[`PAFE_MODE_IND_GAIN];

   // Gain, bias and integrator routing for the first slot
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         first_slot_chain_mode_code   <= 8'h00;
         first_slot_integrator_bypass <= 1'b0;
         first_slot_amp_bias_select   <= 2'h0;
         first_slot_ch1_gain          <= 2'h0;
         first_slot_ch2_gain          <= 2'h0;
         first_slot_ch3_gain          <= 2'h0;
         first_slot_ch4_gain          <= 2'h0;
      end else begin
         first_slot_chain_mode_code <= mode_q[`PAFE_MODE_CODE_HI:`PAFE_MODE_CODE_LO];
         // Digital integration forces the buffer configuration on its own
         first_slot_integrator_bypass <= mode_q[`PAFE_MODE_BYPASS]
                                         | enable_q[`PAFE_EN_FIRST_INT];
         first_slot_amp_bias_select <= mode_q[`PAFE_MODE_BIAS_HI:`PAFE_MODE_BIAS_LO];
         // Channel one always follows the local code
         first_slot_ch1_gain <= shared_gain;
         if (ind_gain) begin
            first_slot_ch2_gain <= ext_channel_gain[1:0];
            first_slot_ch3_gain <= ext_channel_gain[3:2];
            first_slot_ch4_gain <= ext_channel_gain[5:4];
         end else begin
            first_slot_ch2_gain <= shared_gain;
            first_slot_ch3_gain <= shared_gain;
            first_slot_ch4_gain <= shared_gain;
         end
      end
   end

   // Protection bits carry no meaning for this bank
   logic unused_prot;
   assign unused_prot = ^{s_axi_awprot, s_axi_arprot, w_data_q[31:16], w_strb_q[3:2]};

endmodule

// [dv/pafe_slot_config_monitor.sv]
// Purpose: Bus and control relations of the slot config bank
// Assumes: Sees only the top module ports, one clock domain
// Notes:   Bound into the bank at the foot
`timescale 1ns/100ps

module pafe_slot_config_monitor (
   input wire logic        clock,
   input wire logic        rstn,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        second_slot_active,
   input wire logic [4:0]  second_slot_window_fine_delay,
   input wire logic [5:0]  ext_channel_gain,
   input wire logic        first_slot_integrate_select,
   input wire logic        first_slot_integrator_bypass,
   input wire logic [4:0]  region_gap,
   input wire logic [5:0]  first_slot_window_coarse_delay,
   input wire logic [4:0]  first_slot_window_fine_delay,
   input wire logic [10:0] first_slot_window_start,
   input wire logic [1:0]  first_slot_ch1_gain,
   input wire logic [1:0]  first_slot_ch2_gain,
   input wire logic [1:0]  first_slot_ch3_gain,
   input wire logic [1:0]  first_slot_ch4_gain
);

   // One domain: clock and reset given once
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);

   ////////////////////////////////////////////////////////////////////////////////
   // Bus handshakes: an answer stands until the master takes it
   sequence s_b_wait;
      s_axi_bvalid && !s_axi_bready;
   endsequence
   sequence s_r_wait;
      s_axi_rvalid && !s_axi_rready;
   endsequence
   property p_b_hold;
      s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold)
      else $error("write answer dropped early");
   property p_r_hold;
      s_r_wait |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold)
      else $error("read answer dropped early");
   // Upper half of read data is zero
   property p_r_upper;
      s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
   endproperty
   a_r_upper: assert property (p_r_upper)
      else $error("read upper half not zero");
   // No new write taken while its answer waits
   property p_w_busy;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_w_busy: assert property (p_w_busy)
      else $error("write taken under pending answer");
   property p_r_busy;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_r_busy: assert property (p_r_busy)
      else $error("read taken under pending answer");

   ////////////////////////////////////////////////////////////////////////////////
   // Controls: integrate mode forces the buffer setting
   property p_bypass;
      first_slot_integrate_select |-> first_slot_integrator_bypass;
   endproperty
   a_bypass: assert property (p_bypass)
      else $error("integrator not buffered in integrate mode");
   // Window start in fine steps, 32 per coarse step
   property p_start;
      first_slot_window_start == {first_slot_window_coarse_delay, 5'h00}
                                 + first_slot_window_fine_delay;
   endproperty
   a_start: assert property (p_start)
      else $error("window start mismatch");
   // A nonzero gap comes from the running slot's fine delay
   property p_gap;
      region_gap != 5'h00 |-> region_gap == ($past(second_slot_active)
         ? $past(second_slot_window_fine_delay) : first_slot_window_fine_delay);
   endproperty
   a_gap: assert property (p_gap)
      else $error("gap from wrong source");
   // Channels 2 to 4 differ from channel 1 only under individual gain
   property p_gain;
      (first_slot_ch2_gain != first_slot_ch1_gain || first_slot_ch3_gain != first_slot_ch1_gain
       || first_slot_ch4_gain != first_slot_ch1_gain) |->
      {first_slot_ch4_gain, first_slot_ch3_gain, first_slot_ch2_gain} == $past(ext_channel_gain);
   endproperty
   a_gain: assert property (p_gain)
      else $error("channel gain routing wrong");

endmodule

bind pafe_slot_config pafe_slot_config_monitor i_mon (.*);

// [dv/tb_top.sv]
// Purpose: Self-checking bench of the slot config bank
// Assumes: Only the watchdog ends a bus wait
// Notes:   Expectations come from field layout
`timescale 1ns/100ps
`include "pafe_defines.svh"

module tb_top;

   logic clock, rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [9:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic second_slot_active, second_slot_integrate_select, first_slot_integrate_select;
   logic second_slot_pair_count_select, first_slot_pair_count_select;
   logic [4:0] second_slot_window_fine_delay, region_gap, first_slot_window_width;
   logic [5:0] ext_channel_gain, first_slot_window_coarse_delay;
   logic [4:0] first_slot_window_fine_delay;
   logic [10:0] first_slot_window_start;
   logic [7:0] first_slot_chain_mode_code;
   logic first_slot_integrator_bypass;
   logic [1:0] first_slot_amp_bias_select, first_slot_ch1_gain, first_slot_ch2_gain;
   logic [1:0] first_slot_ch3_gain, first_slot_ch4_gain;
   int error_cnt = 0;
   int n_checks = 0;

   // Protection bits are not decoded, so they stay tied
   pafe_slot_config i_dut (.*, .s_axi_awprot(3'h0), .s_axi_arprot(3'h0));

   // 200 MHz clock
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Compare, bus and settle helpers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // Ready raised only on the answer, so its hold is exercised
   task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] er);
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge clock);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b1;
      @(posedge clock);
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp, er, "bresp");
   endtask

   task automatic rd(input logic [9:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge clock);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b1;
      @(posedge clock);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, ed, "rdata");
      chk(s_axi_rresp, er, "rresp");
   endtask

   // Controls are registered: let one more edge land
   task automatic settle;
      @(posedge clock);
      @(negedge clock);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_reset;
      settle();
      chk(first_slot_window_width, 5'h04, "width");
      chk(first_slot_window_coarse_delay, 6'h17, "coarse");
      chk(first_slot_window_fine_delay, 5'h1c, "fine");
      chk(first_slot_amp_bias_select, 2'h3, "bias");
      chk({first_slot_integrate_select, second_slot_integrate_select, region_gap}, 0,
          "idle");
      rd(`PAFE_ADDR_WINDOW, {16'h0, 5'h04, 6'h17, 5'h1c}, `PAFE_RESP_OKAY);
      rd(`PAFE_ADDR_MODE, {16'h0, 8'h1c, 2'b00, 2'h3, 2'h2, 2'h0}, `PAFE_RESP_OKAY);
      rd(`PAFE_ADDR_INT_OPTIONS, 0, `PAFE_RESP_OKAY);
   endtask

   task automatic t_enable;
      wr(`PAFE_ADDR_INT_ENABLE, 32'h2000, 4'h3, `PAFE_RESP_OKAY);
      settle();
      chk({second_slot_integrate_select, first_slot_integrate_select}, 2'b10, "int b");
      chk(first_slot_integrator_bypass, 1'b0, "bypass off");
      wr(`PAFE_ADDR_INT_ENABLE, 32'h1000, 4'h3, `PAFE_RESP_OKAY);
      settle();
      chk({second_slot_integrate_select, first_slot_integrate_select}, 2'b01, "int a");
      chk(first_slot_integrator_bypass, 1'b1, "bypass auto");
      rd(`PAFE_ADDR_INT_ENABLE, 32'h1000, `PAFE_RESP_OKAY);
      wr(`PAFE_ADDR_INT_ENABLE, 32'h0, 4'h3, `PAFE_RESP_OKAY);
   endtask

   // Junk upper lanes, then a one-lane write
   task automatic t_window;
      wr(`PAFE_ADDR_WINDOW, 32'habcd_ffff, 4'hf, `PAFE_RESP_OKAY);
      settle();
      chk(first_slot_window_width, 5'h1f, "width max");
      chk(first_slot_window_start, 11'h7ff, "start max");
      wr(`PAFE_ADDR_WINDOW, 32'h0, 4'h1, `PAFE_RESP_OKAY);
      settle();
      chk(first_slot_window_coarse_delay, 6'h38, "coarse lane");
      rd(`PAFE_ADDR_WINDOW, 32'hff00, `PAFE_RESP_OKAY);
   endtask

   task automatic t_options;
      wr(`PAFE_ADDR_WINDOW, {16'h0, 5'h04, 6'h17, 5'h05}, 4'h3, `PAFE_RESP_OKAY);
      wr(`PAFE_ADDR_INT_OPTIONS, 32'h40, 4'h1, `PAFE_RESP_OKAY);
      settle();
      chk({second_slot_pair_count_select, first_slot_pair_count_select}, 2'b10, "pb");
      chk(region_gap, 5'h00, "no gap");
      wr(`PAFE_ADDR_INT_OPTIONS, 32'ha0, 4'h1, `PAFE_RESP_OKAY);
      settle();
      chk({second_slot_pair_count_select, first_slot_pair_count_select}, 2'b01, "pa");
      chk(region_gap, 5'h05, "gap a");
      @(posedge clock);
      second_slot_active <= 1'b1;
      second_slot_window_fine_delay <= 5'h0b;
      settle();
      chk(region_gap, 5'h0b, "gap b");
      wr(`PAFE_ADDR_INT_OPTIONS, 32'h0, 4'h1, `PAFE_RESP_OKAY);
      settle();
      chk(region_gap, 5'h00, "gap off");
   endtask

   // Shared gain and bias codes, then per-channel
   task automatic t_mode;
      logic [1:0] g;
      for (int i = 0; i < 4; i++) begin
         g = i[1:0];
         wr(`PAFE_ADDR_MODE, {16'h0, 8'h1c, 2'b00, g, 2'b01, g}, 4'h3, `PAFE_RESP_OKAY);
         settle();
         chk(first_slot_amp_bias_select, g, "bias code");
         chk({first_slot_ch4_gain, first_slot_ch3_gain, first_slot_ch2_gain,
              first_slot_ch1_gain}, {4{g}}, "shared gain");
      end
      @(posedge clock);
      ext_channel_gain <= 6'b10_01_11;
      wr(`PAFE_ADDR_MODE, {16'h0, 8'h1d, 2'b11, 2'h3, 2'b01, 2'h2}, 4'h3, `PAFE_RESP_OKAY);
      settle();
      chk(first_slot_chain_mode_code, 8'h1d, "code");
      chk(first_slot_integrator_bypass, 1'b1, "bypass bit");
      chk({first_slot_ch4_gain, first_slot_ch3_gain, first_slot_ch2_gain,
           first_slot_ch1_gain}, 8'b10_01_11_10, "ind gain");
   endtask

   task automatic t_unmapped;
      wr(10'h100, 32'h1234, 4'hf, `PAFE_RESP_SLVERR);
      rd(10'h100, 0, `PAFE_RESP_SLVERR);
      rd(10'h0e5, 0, `PAFE_RESP_SLVERR);
      rd(`PAFE_ADDR_MODE, {16'h0, 8'h1d, 2'b11, 2'h3, 2'b01, 2'h2}, `PAFE_RESP_OKAY);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Verdict and run control
   task automatic stop_test;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // A run takes well under 1000 cycles
   initial begin
      #50000;
      error_cnt++;
      stop_test();
   end

   initial begin
      rstn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      second_slot_active = 1'b0;
      second_slot_window_fine_delay = 5'h00;
      ext_channel_gain = 6'h00;
      repeat (5) @(posedge clock);
      rstn <= 1'b1;
      t_reset();
      t_enable();
      t_window();
      t_options();
      t_mode();
      t_unmapped();
      stop_test();
   end

endmodule
